// ===== logic/hpc_pkg.sv
package hpc_pkg;
  localparam logic [7:0] OFF_FIXED_ATTACH = 8'h09;
  localparam logic [7:0] OFF_SP_OFF_MASK = 8'h0a;
  localparam logic [7:0] OFF_BP_OFF_MASK = 8'h0b;
  localparam logic [7:0] OFF_SP_DRAW = 8'h0c;
  localparam logic [7:0] OFF_BP_DRAW = 8'h0d;

  localparam logic [7:0] RST_FIXED_ATTACH = 8'h00;
  localparam logic [7:0] RST_SP_OFF_MASK = 8'h00;
  localparam logic [7:0] RST_BP_OFF_MASK = 8'h00;
  localparam logic [7:0] RST_SP_DRAW = 8'h01;
  localparam logic [7:0] RST_BP_DRAW = 8'h00;

  localparam int NUM_PORTS = 3;
  localparam int FIRST_PORT_BIT = 1;
  localparam logic [7:0] PORT_BITS = 8'h0e;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [1:0] PORT_NONE = 2'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } hpc_cfg_req_t;

  typedef struct packed {
    logic [1:0] port_count;
    logic [7:0] removable;
    logic [7:0] draw_units;
    logic [7:0] active_ports;
    logic [1:0] map1;
    logic [1:0] map2;
    logic [1:0] map3;
    logic compound;
    logic compound_mismatch;
  } hpc_desc_t;

  typedef struct packed {
    logic sp_s1;
    logic sp_s2;
    logic [7:0] rd_data;
    hpc_desc_t desc;
  } hpc_state_t;
endpackage : hpc_pkg

// ===== logic/hpc_cfg_byte.sv
`timescale 1ns/10ps
module hpc_cfg_byte #(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire hpc_pkg::hpc_cfg_req_t req_in,
  output logic [7:0] q_out
);
  logic [7:0] q_r;
  logic [7:0] q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (req_in.wr && (req_in.addr == ADDR)) begin
      q_nxt = req_in.data;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_r <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_out = q_r;
endmodule : hpc_cfg_byte

// ===== logic/hpc_port_power_cfg.sv
// Operation
// - fixed attach map: bits 1..3 flag ports 1..3 permanently attached
// - host sees fixed-attach flag for each active port from that map
// - self-powered, standard numbering: masked ports stay disabled, never enumerated
// - bus-powered, standard numbering: masked ports disabled; mask resets to zero
// - report count of enabled ports only, renumber them contiguously
// - self-powered draw byte in 2 mA units, resets to one unit
// - bus-powered draw byte in 2 mA units for bus-powered operation
// - remap select zero uses disable masks, one uses table remapping
// - compound flag marks hub compound; affected ports must be fixed-attach
`timescale 1ns/10ps
module hpc_port_power_cfg (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  input wire logic self_powered_in,
  input wire logic port_remap_select_in,
  input wire logic compound_in,
  output logic [1:0] port_count_out,
  output logic [7:0] removable_out,
  output logic [7:0] draw_units_out,
  output logic [7:0] active_ports_out,
  output logic [1:0] map1_out,
  output logic [1:0] map2_out,
  output logic [1:0] map3_out,
  output logic compound_out,
  output logic compound_mismatch_out
);
  hpc_pkg::hpc_cfg_req_t req;
  hpc_pkg::hpc_state_t st_r;
  hpc_pkg::hpc_state_t st_nxt;
  logic [7:0] fixed_attach_flags;
  logic [7:0] self_powered_off_mask;
  logic [7:0] bus_powered_off_mask;
  logic [7:0] self_powered_draw_units;
  logic [7:0] bus_powered_draw_units;

  assign req = '{wr: cfg_wr_in, rd: cfg_rd_in, addr: cfg_addr_in, data: cfg_wdata_in};

  // all eight bits are stored and read back; only port bits steer the hub
  hpc_cfg_byte #(.ADDR(hpc_pkg::OFF_FIXED_ATTACH), .RST_VAL(hpc_pkg::RST_FIXED_ATTACH))
    u_fixed (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req), .q_out(fixed_attach_flags));
  hpc_cfg_byte #(.ADDR(hpc_pkg::OFF_SP_OFF_MASK), .RST_VAL(hpc_pkg::RST_SP_OFF_MASK))
    u_sp_off (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req),
      .q_out(self_powered_off_mask));
  hpc_cfg_byte #(.ADDR(hpc_pkg::OFF_BP_OFF_MASK), .RST_VAL(hpc_pkg::RST_BP_OFF_MASK))
    u_bp_off (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req),
      .q_out(bus_powered_off_mask));
  hpc_cfg_byte #(.ADDR(hpc_pkg::OFF_SP_DRAW), .RST_VAL(hpc_pkg::RST_SP_DRAW))
    u_sp_draw (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req),
      .q_out(self_powered_draw_units));
  hpc_cfg_byte #(.ADDR(hpc_pkg::OFF_BP_DRAW), .RST_VAL(hpc_pkg::RST_BP_DRAW))
    u_bp_draw (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req),
      .q_out(bus_powered_draw_units));

  always_comb begin
    logic [7:0] off_mask;
    logic [1:0] cnt;
    logic [1:0] map [1:3];
    off_mask = 8'h00;
    cnt = 2'h0;
    map[1] = hpc_pkg::PORT_NONE;
    map[2] = hpc_pkg::PORT_NONE;
    map[3] = hpc_pkg::PORT_NONE;
    st_nxt = st_r;
    // pin level from the board: two flops before anything looks at it
    st_nxt.sp_s1 = self_powered_in;
    st_nxt.sp_s2 = st_r.sp_s1;
    // mode follows the synchronised pin and the current remap select
    if (!port_remap_select_in) begin
      off_mask = st_r.sp_s2 ? self_powered_off_mask : bus_powered_off_mask;
    end
    // remap tables live elsewhere; in that mode every port stays active
    st_nxt.desc.active_ports = ~off_mask & hpc_pkg::PORT_BITS;
    st_nxt.desc.removable = 8'h00;
    for (int p = hpc_pkg::FIRST_PORT_BIT; p <= hpc_pkg::NUM_PORTS; p++) begin
      if (!off_mask[p]) begin
        cnt = cnt + 2'h1;
        map[cnt] = p[1:0];
        st_nxt.desc.removable[cnt] = fixed_attach_flags[p];
      end
    end
    st_nxt.desc.port_count = cnt;
    st_nxt.desc.map1 = map[1];
    st_nxt.desc.map2 = map[2];
    st_nxt.desc.map3 = map[3];
    st_nxt.desc.draw_units = st_r.sp_s2 ? self_powered_draw_units
                                        : bus_powered_draw_units;
    st_nxt.desc.compound = compound_in;
    // compound with no active fixed-attach port is a configuration slip
    st_nxt.desc.compound_mismatch = compound_in &&
      ((fixed_attach_flags & st_nxt.desc.active_ports) == 8'h00);
    // reads answer one cycle later from a flop; unmapped offsets read zero
    st_nxt.rd_data = st_r.rd_data;
    if (cfg_rd_in) begin
      case (cfg_addr_in)
        hpc_pkg::OFF_FIXED_ATTACH: st_nxt.rd_data = fixed_attach_flags;
        hpc_pkg::OFF_SP_OFF_MASK: st_nxt.rd_data = self_powered_off_mask;
        hpc_pkg::OFF_BP_OFF_MASK: st_nxt.rd_data = bus_powered_off_mask;
        hpc_pkg::OFF_SP_DRAW: st_nxt.rd_data = self_powered_draw_units;
        hpc_pkg::OFF_BP_DRAW: st_nxt.rd_data = bus_powered_draw_units;
        default: st_nxt.rd_data = hpc_pkg::RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata_out = st_r.rd_data;
  assign port_count_out = st_r.desc.port_count;
  assign removable_out = st_r.desc.removable;
  assign draw_units_out = st_r.desc.draw_units;
  assign active_ports_out = st_r.desc.active_ports;
  assign map1_out = st_r.desc.map1;
  assign map2_out = st_r.desc.map2;
  assign map3_out = st_r.desc.map3;
  assign compound_out = st_r.desc.compound;
  assign compound_mismatch_out = st_r.desc.compound_mismatch;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // descriptor flops lag their inputs by one edge and show zeros on the edge after reset
  a_sp_mask_off: assert property ($past(st_r.sp_s2 && !port_remap_select_in) |->
    ((active_ports_out & $past(self_powered_off_mask) & hpc_pkg::PORT_BITS) == 8'h00))
    else $error("self-powered masked port is active");
  a_sp_mask_on: assert property (!$past(rst_in) &&
    $past(st_r.sp_s2 && !port_remap_select_in) |->
    active_ports_out == (~$past(self_powered_off_mask) & hpc_pkg::PORT_BITS))
    else $error("self-powered open port is missing");
  a_bp_mask_off: assert property ($past(!st_r.sp_s2 && !port_remap_select_in) |->
    ((active_ports_out & $past(bus_powered_off_mask) & hpc_pkg::PORT_BITS) == 8'h00))
    else $error("bus-powered masked port is active");
  a_bp_mask_on: assert property (!$past(rst_in) &&
    $past(!st_r.sp_s2 && !port_remap_select_in) |->
    active_ports_out == (~$past(bus_powered_off_mask) & hpc_pkg::PORT_BITS))
    else $error("bus-powered open port is missing");
  a_port_count: assert property (port_count_out == 2'($countones(active_ports_out)))
    else $error("port count differs from active ports");
  a_map_order: assert property (port_count_out >= 2'h2 |->
    (map1_out < map2_out) && active_ports_out[map1_out])
    else $error("logical numbering not contiguous");
  a_map_tail: assert property (port_count_out == 2'h3 |->
    (map2_out < map3_out) && active_ports_out[map3_out])
    else $error("last logical port out of order");
  a_map1_unused: assert property (port_count_out == 2'h0 |->
    map1_out == hpc_pkg::PORT_NONE)
    else $error("logical port 1 mapped with no ports");
  a_map2_unused: assert property (port_count_out < 2'h2 |->
    map2_out == hpc_pkg::PORT_NONE)
    else $error("logical port 2 mapped beyond count");
  a_map3_unused: assert property (port_count_out < 2'h3 |->
    map3_out == hpc_pkg::PORT_NONE)
    else $error("logical port 3 mapped beyond count");
  a_sp_draw: assert property ($past(st_r.sp_s2) |->
    draw_units_out == $past(self_powered_draw_units))
    else $error("self-powered draw not reported");
  a_bp_draw: assert property ($past(!st_r.sp_s2) |->
    draw_units_out == $past(bus_powered_draw_units))
    else $error("bus-powered draw not reported");
  a_sync_pin: assert property (!$past(rst_in, 2) |->
    st_r.sp_s2 == $past(self_powered_in, 2))
    else $error("power pin not seen two edges later");
  a_reserved_quiet: assert property (removable_out[0] == 1'b0 &&
    (active_ports_out & ~hpc_pkg::PORT_BITS) == 8'h00)
    else $error("reserved bit affects ports");
  a_removable_slots: assert property (
    (removable_out >> (3'(port_count_out) + 3'h1)) == 8'h00)
    else $error("fixed attach flag beyond last logical port");
  a_fixed_flags: assert property ($past(port_remap_select_in) |->
    removable_out == ($past(fixed_attach_flags) & hpc_pkg::PORT_BITS))
    else $error("fixed attach flags misreported");
  a_remap_all: assert property ($past(port_remap_select_in) && !$past(rst_in) |->
    port_count_out == 2'h3)
    else $error("remap mode lost a port");
  a_remap_map: assert property ($past(port_remap_select_in) && !$past(rst_in) |->
    map1_out == 2'h1 && map2_out == 2'h2 && map3_out == 2'h3)
    else $error("remap mode renumbered a port");
  a_compound_copy: assert property (!$past(rst_in) |->
    compound_out == $past(compound_in))
    else $error("compound flag not reported");
  a_mismatch_flag: assert property (
    compound_mismatch_out == (compound_out && removable_out == 8'h00))
    else $error("compound without fixed attach port not flagged");
  a_read_back: assert property (cfg_rd_in && !cfg_wr_in &&
    cfg_addr_in == hpc_pkg::OFF_SP_DRAW |=> cfg_rdata_out == $past(self_powered_draw_units))
    else $error("draw byte read back wrong");
  a_read_fixed: assert property (cfg_rd_in &&
    cfg_addr_in == hpc_pkg::OFF_FIXED_ATTACH |=> cfg_rdata_out == $past(fixed_attach_flags))
    else $error("fixed attach byte read back wrong");
  a_read_sp_mask: assert property (cfg_rd_in &&
    cfg_addr_in == hpc_pkg::OFF_SP_OFF_MASK |=> cfg_rdata_out == $past(self_powered_off_mask))
    else $error("self-powered mask read back wrong");
  a_read_bp_mask: assert property (cfg_rd_in &&
    cfg_addr_in == hpc_pkg::OFF_BP_OFF_MASK |=> cfg_rdata_out == $past(bus_powered_off_mask))
    else $error("bus-powered mask read back wrong");
  a_read_bp_draw: assert property (cfg_rd_in &&
    cfg_addr_in == hpc_pkg::OFF_BP_DRAW |=> cfg_rdata_out == $past(bus_powered_draw_units))
    else $error("bus-powered draw read back wrong");
  a_read_unmapped: assert property (cfg_rd_in &&
    (cfg_addr_in < hpc_pkg::OFF_FIXED_ATTACH || cfg_addr_in > hpc_pkg::OFF_BP_DRAW) |=>
    cfg_rdata_out == hpc_pkg::RD_UNMAPPED)
    else $error("unmapped offset read not zero");
  a_rdata_hold: assert property (!$past(cfg_rd_in) |-> $stable(cfg_rdata_out))
    else $error("read data moved without a read");

  c_all_off: cover property (port_count_out == 2'h0);
  c_port2_off: cover property (active_ports_out == 8'h0a && map2_out == 2'h3);
  c_compound: cover property (compound_out && !compound_mismatch_out);
  c_mode_swap: cover property ($rose(st_r.sp_s2) ##1 draw_units_out == self_powered_draw_units);
  c_remap_mode: cover property (port_remap_select_in && compound_mismatch_out);
endmodule : hpc_port_power_cfg

// ===== verif/hpc_cfg_master.sv
`timescale 1ns/10ps
module hpc_cfg_master (
  input wire logic core_clk_in,
  input wire logic [7:0] rdata_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    // a configurer never asks for more than 100 mA self-powered
    if (a === hpc_pkg::OFF_SP_DRAW && d > 8'h32) d = 8'h32;
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge core_clk_in);
    wr_out <= 1'b0;
    // released bus shows inverse so stale data cannot pass
    wdata_out <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge core_clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge core_clk_in);
    #1;
    d = rdata_in;
  endtask : rd
endmodule : hpc_cfg_master

// ===== verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sp = 1'b0;
  logic rmp = 1'b0;
  logic cmp = 1'b0;
  logic wr, rd, mis, cmpo;
  logic [7:0] addr, wdata, rdata, rem, draw, act, d;
  logic [1:0] cnt, m1, m2, m3;
  logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  int failures = 0;
  int n_checks = 0;
  always #2.5 core_clk_in = ~core_clk_in;
  hpc_cfg_master mst_u (.core_clk_in(core_clk_in), .rdata_in(rdata), .wr_out(wr),
    .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
  hpc_port_power_cfg dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .cfg_wr_in(wr),
    .cfg_rd_in(rd), .cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata),
    .self_powered_in(sp), .port_remap_select_in(rmp), .compound_in(cmp),
    .port_count_out(cnt), .removable_out(rem), .draw_units_out(draw),
    .active_ports_out(act), .map1_out(m1), .map2_out(m2), .map3_out(m3),
    .compound_out(cmpo), .compound_mismatch_out(mis));
  task conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // expected host view: logical k is the k-th lowest enabled physical port
  task desc(input logic [7:0] msk, input logic [7:0] fix, input logic [7:0] dr);
    logic [1:0] k;
    logic [3:1][1:0] mp;
    logic [7:0] r;
    logic [7:0] a;
    k = 2'h0;
    mp = '0;
    r = 8'h00;
    a = 8'h0e & ~msk;
    for (int p = 1; p <= 3; p++) if (a[p]) begin
      k++;
      mp[k] = p[1:0];
      r[k] = fix[p];
    end
    chk(act, a, "active");
    chk({6'h0, cnt}, {6'h0, k}, "count");
    chk({2'h0, m1, m2, m3}, {2'h0, mp[1], mp[2], mp[3]}, "map");
    chk(rem, r, "removable");
    chk(draw, dr, "draw");
    chk({6'h0, cmpo, mis}, {6'h0, cmp, cmp && r == 8'h00}, "compound");
  endtask : desc
  initial begin
    #50000;
    failures++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      mst_u.rd(8'h09 + i[7:0], d);
      chk(d, rv[i], "reset value");
    end
    mst_u.wr(8'h08, 8'h5a);
    mst_u.rd(8'h08, d);
    chk(d, 8'h00, "unmapped");
    mst_u.wr(8'h09, 8'hf5);
    mst_u.rd(8'h09, d);
    chk(d, 8'hf5, "readback");
    mst_u.wr(8'h0c, 8'h32);
    mst_u.wr(8'h0d, 8'h7d);
    $display("register test done");
    for (int s = 1; s >= 0; s--) begin
      @(posedge core_clk_in);
      sp <= s[0];
      cmp <= ~s[0];
      // reserved bits set in the live mask, the other mode's mask inverted
      for (int m = 0; m < 8; m++) begin
        mst_u.wr(s ? 8'h0a : 8'h0b, {4'hf, m[2:0], 1'b1});
        mst_u.wr(s ? 8'h0b : 8'h0a, {4'h0, ~m[2:0], 1'b0});
        repeat (3) @(posedge core_clk_in);
        #1;
        desc({4'hf, m[2:0], 1'b1}, 8'hf5, s ? 8'h32 : 8'h7d);
      end
    end
    $display("descriptor test done");
    @(posedge core_clk_in);
    rmp <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1;
    desc(8'h00, 8'hf5, 8'h7d);
    $display("remap test done");
    // second reset with remap still selected: written bytes must fall back
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    mst_u.rd(8'h0b, d);
    chk(d, rv[2], "bus mask after reset");
    mst_u.rd(8'h0c, d);
    chk(d, rv[3], "self draw after reset");
    desc(8'h00, 8'h00, 8'h00);
    $display("reset test done");
    conclude();
  end
endmodule : tb_top
